// file: rtl/pst_top.sv
// PCM serial port timebase with register slave
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Tx data, sync, insert sampled on falling tx edge, marker on rising; invertible.
// - Tx clock may be replaced by the receive or external clock.
// - Rx clock times rx outputs; recovered by default, or external, or tx clock.
// - Rx outputs change on rising rx edge, or falling edge when inverted.
// - External clock may source rx alone or rx and tx, either polarity.
// - A tx frame holds up to 64 byte timeslots plus optional framing bit.
// - Sampled tx bits and framing bits are passed on as channel payload.
// - Rx frame of up to 64 timeslots plus framing bit from channel payload.
// - Framed mode: tx sync rising edge resets tx timebase; otherwise it is ignored.
// - Tx sync rising edge delayed by bit and frame offset onto bit 0 frame 0.
// - Rx sync pulses one rx clock with bit 0 of frame 0.
// - Bit 0 is first timeslot bit, or the framing bit when present.
// - Bit and frame offsets move the rx sync pulse to any bit.
// - Master sync pulses one tx clock, two cycles before bit 0 frame 0.
// - Master sync follows applied tx sync, else serves as the frame reference.
// - Drop marker high 8 bits per selected slot, 1 bit per framing bit.
// - Any combination of slots and framing bits selectable for dropping.
// - While insert marker is high, insert data replaces tx serial data.
// - Insert marker high 8 bits per selected slot, 1 bit per framing bit.
module pst_top (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic [pst_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [pst_pkg::DATA_W-1:0] avs_writedata,
	input  wire logic [pst_pkg::BE_W-1:0]   avs_byteenable,
	output logic [pst_pkg::DATA_W-1:0] avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic                  txBitClock,
	input  wire logic                  externalRefClock,
	input  wire logic                  clockRecoveryLoopClk,
	input  wire logic                  txSerialIn,
	input  wire logic                  txFrameSyncIn,
	input  wire logic                  replaceDataIn,
	output logic                       insertMarker,
	output logic                       txMasterSyncOut,
	output logic                       txPayloadBit,
	output logic                       txPayloadValid,
	output logic                       txPayloadFbit,
	input  wire logic                  rxPayloadBit,
	output logic                       rxPayloadReq,
	output logic                       rxBitClockOut,
	output logic                       rxSerialOut,
	output logic                       rxFrameSyncOut,
	output logic                       dropMarker
);
	import pst_pkg::*;

	typedef struct packed {
		logic [NPIN-1:0]  sy1;
		logic [NPIN-1:0]  sy2;
		logic             txPrev;
		logic             rxPrev;
		logic             syncPrev;
		pst_ctrl_t        ctrl;
		pst_frm_t         frm;
		pst_off_t         txOff;
		pst_off_t         rxOff;
		logic [NSLOT-1:0] dropMask;
		logic [NSLOT-1:0] insMask;
		pst_fmask_t       fMask;
		pst_cfg_t         actTx;
		pst_cfg_t         actRx;
		logic             waitReq;
		logic [DATA_W-1:0] rdata;
		logic             insMark;
		logic             tx_master_sync_out;
		logic             rxClk;
		logic             rxSer;
		logic             rxSync;
		logic             drop;
		logic             payBit;
		logic             payValid;
		logic             payF;
		logic             rxReq;
	} pst_st_t;

	localparam pst_cfg_t CFG_RST = '{ctrl: CTRL_RST, frm: FRM_RST, off: OFF_RST};
	localparam pst_st_t ST_RST = '{ctrl: CTRL_RST, frm: FRM_RST, txOff: OFF_RST,
		rxOff: OFF_RST, actTx: CFG_RST, actRx: CFG_RST, waitReq: 1'b1, default: '0};

	pst_st_t         s;
	pst_st_t         next_s;
	logic [NPIN-1:0] pins;
	logic            txLvl;
	logic            rxLvl;
	logic            txRise;
	logic            txFall;
	logic            rxRise;
	logic            rxFall;
	logic            txSmp;
	logic            txDrv;
	logic            rxDrv;
	logic            syncRise;
	logic            busReq;
	logic            wrNow;
	logic [DATA_W-1:0] wd;
	pst_cfg_t        cfgTx;
	pst_cfg_t        cfgRx;

	pst_tb_if txIf ();
	pst_tb_if rxIf ();

	pst_timebase u_txTb (
		.clk  (clk),
		.srst (srst),
		.tb   (txIf.tb)
	);

	pst_timebase u_rxTb (
		.clk  (clk),
		.srst (srst),
		.tb   (rxIf.tb)
	);

	// Byte lanes not enabled keep their old contents
	function automatic logic [DATA_W-1:0] pst_merge(input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] nw, input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < BE_W; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : pst_merge

	function automatic logic pst_hit(input logic [NSLOT-1:0] m,
		input logic [SLOT_W-1:0] slot, input logic isF, input logic fSel);
		return isF ? fSel : m[slot];
	endfunction : pst_hit

	assign pins = {replaceDataIn, txFrameSyncIn, txSerialIn,
		clockRecoveryLoopClk, externalRefClock, txBitClock};

	// Clock sources follow the active copies, so a switch lands on a frame edge
	always_comb begin
		unique case (s.actRx.ctrl.rxSel)
			RXS_REC: rxLvl = s.sy2[PIN_REC];
			RXS_EXT: rxLvl = s.sy2[PIN_EXT];
			RXS_TX:  rxLvl = s.sy2[PIN_TXC];
			default: rxLvl = s.sy2[PIN_REC];
		endcase
		unique case (s.actTx.ctrl.txSel)
			TXS_PIN: txLvl = s.sy2[PIN_TXC];
			TXS_RX:  txLvl = rxLvl;
			TXS_EXT: txLvl = s.sy2[PIN_EXT];
			default: txLvl = s.sy2[PIN_TXC];
		endcase
	end

	assign txRise   = txLvl && !s.txPrev;
	assign txFall   = !txLvl && s.txPrev;
	assign rxRise   = rxLvl && !s.rxPrev;
	assign rxFall   = !rxLvl && s.rxPrev;
	assign txSmp    = s.actTx.ctrl.txInv ? txRise : txFall;
	assign txDrv    = s.actTx.ctrl.txInv ? txFall : txRise;
	assign rxDrv    = s.actRx.ctrl.rxInv ? rxFall : rxRise;
	assign syncRise = s.sy2[PIN_SYNC] && !s.syncPrev;

	assign txIf.step      = txSmp && !txIf.load;
	assign txIf.load      = txSmp && syncRise && s.actTx.ctrl.framed;
	assign txIf.fbitEn    = s.actTx.ctrl.fbitEn;
	assign txIf.slotsM1   = s.actTx.frm.slotsM1;
	assign txIf.framesM1  = s.actTx.frm.framesM1;
	assign txIf.loadBit   = s.actTx.off.bitOff;
	assign txIf.loadFrame = s.actTx.off.frameOff;
	assign rxIf.step      = rxDrv;
	assign rxIf.load      = 1'b0;
	assign rxIf.fbitEn    = s.actRx.ctrl.fbitEn;
	assign rxIf.slotsM1   = s.actRx.frm.slotsM1;
	assign rxIf.framesM1  = s.actRx.frm.framesM1;
	assign rxIf.loadBit   = '0;
	assign rxIf.loadFrame = '0;

	assign cfgTx  = '{ctrl: s.ctrl, frm: s.frm, off: s.txOff};
	assign cfgRx  = '{ctrl: s.ctrl, frm: s.frm, off: s.rxOff};
	assign busReq = avs_read || avs_write;
	assign wrNow  = avs_write && !s.waitReq;

	always_comb begin
		next_s = s;
		wd = 32'h0000_0000;
		// Pins are asynchronous; only the second stage feeds logic
		next_s.sy1    = pins;
		next_s.sy2    = s.sy1;
		next_s.txPrev = txLvl;
		next_s.rxPrev = rxLvl;
		next_s.rxClk  = rxLvl;

		// Settings move to the running side only on its frame boundary
		if (txIf.step && txIf.frameEnd) begin
			next_s.actTx = cfgTx;
		end
		if (rxIf.step && rxIf.frameEnd) begin
			next_s.actRx = cfgRx;
		end

		// Transmit: marker leads the sample by half a bit
		next_s.payValid = txSmp;
		if (txDrv) begin
			next_s.insMark = pst_hit(s.insMask, txIf.slot, txIf.isF, s.fMask.insF);
			next_s.tx_master_sync_out = txIf.preSync;
		end
		if (txSmp) begin
			next_s.syncPrev = s.sy2[PIN_SYNC];
			next_s.payBit = s.insMark ? s.sy2[PIN_INS] : s.sy2[PIN_SER];
			next_s.payF = txIf.load ? (txIf.fbitEn && txIf.loadBit == '0) : txIf.isF;
		end

		// Receive: all outputs change together on the drive edge
		next_s.rxReq = rxDrv;
		if (rxDrv) begin
			next_s.rxSer = rxPayloadBit;
			next_s.rxSync = (rxIf.bitPos == s.actRx.off.bitOff) &&
				(rxIf.frame == s.actRx.off.frameOff);
			next_s.drop = pst_hit(s.dropMask, rxIf.slot, rxIf.isF, s.fMask.dropF);
		end

		// Avalon slave: one wait cycle, then a single acknowledge cycle
		next_s.waitReq = 1'b1;
		if (busReq && s.waitReq) begin
			next_s.waitReq = 1'b0;
			case (avs_address)
				ADR_CTRL:   next_s.rdata = s.ctrl;
				ADR_FRM:    next_s.rdata = s.frm;
				ADR_TXOFF:  next_s.rdata = s.txOff;
				ADR_RXOFF:  next_s.rdata = s.rxOff;
				ADR_DROPLO: next_s.rdata = s.dropMask[DATA_W-1:0];
				ADR_DROPHI: next_s.rdata = s.dropMask[NSLOT-1:DATA_W];
				ADR_INSLO:  next_s.rdata = s.insMask[DATA_W-1:0];
				ADR_INSHI:  next_s.rdata = s.insMask[NSLOT-1:DATA_W];
				ADR_FMASK:  next_s.rdata = s.fMask;
				ADR_STAT:   next_s.rdata = {rxIf.frame, rxIf.bitPos, txIf.frame, txIf.bitPos};
				default:    next_s.rdata = '0;
			endcase
		end
		if (wrNow) begin
			unique case (avs_address)
				ADR_CTRL: begin
					wd = pst_merge(s.ctrl, avs_writedata, avs_byteenable);
					next_s.ctrl = pst_ctrl_t'(wd & CTRL_WM);
				end
				ADR_FRM: begin
					wd = pst_merge(s.frm, avs_writedata, avs_byteenable);
					next_s.frm = pst_frm_t'(wd & FRM_WM);
				end
				ADR_TXOFF: begin
					wd = pst_merge(s.txOff, avs_writedata, avs_byteenable);
					next_s.txOff = pst_off_t'(wd & OFF_WM);
				end
				ADR_RXOFF: begin
					wd = pst_merge(s.rxOff, avs_writedata, avs_byteenable);
					next_s.rxOff = pst_off_t'(wd & OFF_WM);
				end
				ADR_DROPLO: begin
					wd = pst_merge(s.dropMask[DATA_W-1:0], avs_writedata, avs_byteenable);
					next_s.dropMask[DATA_W-1:0] = wd;
				end
				ADR_DROPHI: begin
					wd = pst_merge(s.dropMask[NSLOT-1:DATA_W], avs_writedata, avs_byteenable);
					next_s.dropMask[NSLOT-1:DATA_W] = wd;
				end
				ADR_INSLO: begin
					wd = pst_merge(s.insMask[DATA_W-1:0], avs_writedata, avs_byteenable);
					next_s.insMask[DATA_W-1:0] = wd;
				end
				ADR_INSHI: begin
					wd = pst_merge(s.insMask[NSLOT-1:DATA_W], avs_writedata, avs_byteenable);
					next_s.insMask[NSLOT-1:DATA_W] = wd;
				end
				ADR_FMASK: begin
					wd = pst_merge(s.fMask, avs_writedata, avs_byteenable);
					next_s.fMask = pst_fmask_t'(wd & FM_WM);
				end
				default: begin
					wd = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	assign avs_readdata    = s.rdata;
	assign avs_waitrequest = s.waitReq;
	assign insertMarker    = s.insMark;
	assign txMasterSyncOut = s.tx_master_sync_out;
	assign txPayloadBit    = s.payBit;
	assign txPayloadValid  = s.payValid;
	assign txPayloadFbit   = s.payF;
	assign rxPayloadReq    = s.rxReq;
	assign rxBitClockOut   = s.rxClk;
	assign rxSerialOut     = s.rxSer;
	assign rxFrameSyncOut  = s.rxSync;
	assign dropMarker      = s.drop;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	property p_txSample;
		txPayloadValid |-> ($past(txLvl) == $past(s.actTx.ctrl.txInv));
	endproperty
	a_txSample: assert property (p_txSample) else $error("tx sampled on wrong edge");

	property p_insEdge;
		$changed(insertMarker) |-> ($past(txLvl) != $past(s.actTx.ctrl.txInv));
	endproperty
	a_insEdge: assert property (p_insEdge) else $error("insert marker on wrong edge");

	property p_loopTx;
		(s.actTx.ctrl.txSel == TXS_RX) |-> (txLvl == rxLvl);
	endproperty
	a_loopTx: assert property (p_loopTx) else $error("tx clock not looped");

	property p_rxEdge;
		$changed(rxSerialOut) |-> ($past(rxLvl) != $past(s.actRx.ctrl.rxInv));
	endproperty
	a_rxEdge: assert property (p_rxEdge) else $error("rx data on wrong edge");

	property p_extBoth;
		(s.actTx.ctrl.txSel == TXS_EXT && s.actRx.ctrl.rxSel == RXS_EXT) |->
			##1 (rxBitClockOut == $past(txLvl));
	endproperty
	a_extBoth: assert property (p_extBoth) else $error("ext clock not shared");

	property p_ignoreSync;
		txIf.load |-> s.actTx.ctrl.framed;
	endproperty
	a_ignoreSync: assert property (p_ignoreSync) else $error("sync used unframed");

	property p_syncAlign;
		(txIf.load && s.actTx.off.bitOff == '0 && s.actTx.off.frameOff == '0) |=>
			(txIf.bitPos == 10'h001 && txIf.frame == '0);
	endproperty
	a_syncAlign: assert property (p_syncAlign) else $error("sync not on bit 0");

	property p_rxSyncOne;
		(rxFrameSyncOut && rxDrv) |=> !rxFrameSyncOut;
	endproperty
	a_rxSyncOne: assert property (p_rxSyncOne) else $error("rx sync too long");

	property p_tx_master_sync_out;
		$rose(txMasterSyncOut) |-> $past(txIf.preSync && txDrv);
	endproperty
	a_tx_master_sync_out: assert property (p_tx_master_sync_out) else $error("master sync misplaced");

	property p_replace;
		(txSmp && s.insMark) |=> (txPayloadBit == $past(s.sy2[PIN_INS]));
	endproperty
	a_replace: assert property (p_replace) else $error("insert data not used");

	property p_ack;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("double acknowledge");

	c_load: cover property (txIf.load);
	c_rxSync: cover property ($rose(rxFrameSyncOut));
	c_insert: cover property ($rose(insertMarker) ##1 txPayloadValid);
	c_drop: cover property ($rose(dropMarker));
endmodule : pst_top
`default_nettype wire

// file: shared/pst_pkg.sv
// Shared constants and types of the PCM serial port timebase
package pst_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;
	localparam int BIT_W  = 10;
	localparam int FRM_W  = 6;
	localparam int SLOT_W = 6;
	localparam int NSLOT  = 64;
	localparam int NPIN   = 6;
	localparam int PIN_TXC  = 0;
	localparam int PIN_EXT  = 1;
	localparam int PIN_REC  = 2;
	localparam int PIN_SER  = 3;
	localparam int PIN_SYNC = 4;
	localparam int PIN_INS  = 5;
	localparam logic [ADDR_W-1:0] ADR_CTRL   = 6'h00;
	localparam logic [ADDR_W-1:0] ADR_FRM    = 6'h04;
	localparam logic [ADDR_W-1:0] ADR_TXOFF  = 6'h08;
	localparam logic [ADDR_W-1:0] ADR_RXOFF  = 6'h0C;
	localparam logic [ADDR_W-1:0] ADR_DROPLO = 6'h10;
	localparam logic [ADDR_W-1:0] ADR_DROPHI = 6'h14;
	localparam logic [ADDR_W-1:0] ADR_INSLO  = 6'h18;
	localparam logic [ADDR_W-1:0] ADR_INSHI  = 6'h1C;
	localparam logic [ADDR_W-1:0] ADR_FMASK  = 6'h20;
	localparam logic [ADDR_W-1:0] ADR_STAT   = 6'h24;
	localparam logic [DATA_W-1:0] CTRL_WM = 32'h0000_00FF;
	localparam logic [DATA_W-1:0] FRM_WM  = 32'h0000_3F3F;
	localparam logic [DATA_W-1:0] OFF_WM  = 32'h003F_03FF;
	localparam logic [DATA_W-1:0] FM_WM   = 32'h0000_0003;
	typedef enum logic [1:0] {TXS_PIN, TXS_RX, TXS_EXT} pst_txsel_t;
	typedef enum logic [1:0] {RXS_REC, RXS_EXT, RXS_TX} pst_rxsel_t;
	typedef struct packed {
		logic [23:0] rsvd;
		logic        fbitEn;
		logic        framed;
		logic        rxInv;
		logic        txInv;
		pst_rxsel_t  rxSel;
		pst_txsel_t  txSel;
	} pst_ctrl_t;
	typedef struct packed {
		logic [17:0]       rsvd;
		logic [FRM_W-1:0]  framesM1;
		logic [1:0]        gap;
		logic [SLOT_W-1:0] slotsM1;
	} pst_frm_t;
	typedef struct packed {
		logic [9:0]       rsvd;
		logic [FRM_W-1:0] frameOff;
		logic [5:0]       gap;
		logic [BIT_W-1:0] bitOff;
	} pst_off_t;
	typedef struct packed {
		logic [29:0] rsvd;
		logic        insF;
		logic        dropF;
	} pst_fmask_t;
	typedef struct packed {
		pst_ctrl_t ctrl;
		pst_frm_t  frm;
		pst_off_t  off;
	} pst_cfg_t;
	localparam pst_ctrl_t CTRL_RST = pst_ctrl_t'(32'h0000_0040);
	localparam pst_frm_t  FRM_RST  = pst_frm_t'(32'h0000_0F1F);
	localparam pst_off_t  OFF_RST  = pst_off_t'(32'h0000_0000);
endpackage : pst_pkg

// file: shared/pst_tb_if.sv
// Timebase control and position signals
`timescale 1ns/1ps
`default_nettype none
interface pst_tb_if;
	import pst_pkg::*;
	logic              step;
	logic              load;
	logic              fbitEn;
	logic [SLOT_W-1:0] slotsM1;
	logic [FRM_W-1:0]  framesM1;
	logic [BIT_W-1:0]  loadBit;
	logic [FRM_W-1:0]  loadFrame;
	logic [BIT_W-1:0]  bitPos;
	logic [FRM_W-1:0]  frame;
	logic [SLOT_W-1:0] slot;
	logic              isF;
	logic              frameEnd;
	logic              preSync;
	modport tb (input step, load, fbitEn, slotsM1, framesM1, loadBit, loadFrame,
		output bitPos, frame, slot, isF, frameEnd, preSync);
	modport user (output step, load, fbitEn, slotsM1, framesM1, loadBit, loadFrame,
		input bitPos, frame, slot, isF, frameEnd, preSync);
endinterface : pst_tb_if
`default_nettype wire

// file: rtl/pst_timebase.sv
// Bit, timeslot and frame counter of one PCM direction
`timescale 1ns/1ps
`default_nettype none
module pst_timebase (
	input  wire logic clk,
	input  wire logic srst,
	pst_tb_if.tb      tb
);
	import pst_pkg::*;
	typedef struct packed {
		logic [BIT_W-1:0] bitPos;
		logic [FRM_W-1:0] frame;
	} pst_pos_t;
	pst_pos_t         s;
	pst_pos_t         next_s;
	pst_pos_t         tgt;
	logic [BIT_W-1:0] fb;
	logic [BIT_W-1:0] rel;
	logic [FRM_W:0]   frDly;
	logic [FRM_W:0]   mfLen;

	function automatic pst_pos_t pst_adv(input pst_pos_t p, input logic [BIT_W-1:0] n,
		input logic [FRM_W-1:0] fm);
		pst_pos_t r;
		r = p;
		if (p.bitPos == n - 10'h001) begin
			r.bitPos = '0;
			r.frame  = (p.frame == fm) ? '0 : p.frame + 6'h01;
		end else begin
			r.bitPos = p.bitPos + 10'h001;
		end
		return r;
	endfunction : pst_adv

	always_comb begin
		fb = {({1'b0, tb.slotsM1} + 7'h01), 3'h0} + BIT_W'(tb.fbitEn);
		mfLen = {1'b0, tb.framesM1} + 7'h01;
		// Position of this sample so that bit 0, frame 0 comes after the delay
		tgt.bitPos = (tb.loadBit == '0) ? '0 : fb - tb.loadBit;
		frDly = {1'b0, tb.loadFrame} + 7'(tb.loadBit != '0);
		tgt.frame = (frDly == '0) ? '0 : FRM_W'(mfLen - frDly);
		next_s = s;
		if (tb.load) begin
			next_s = pst_adv(tgt, fb, tb.framesM1);
		end else if (tb.step) begin
			next_s = pst_adv(s, fb, tb.framesM1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rel         = s.bitPos - BIT_W'(tb.fbitEn);
	assign tb.bitPos   = s.bitPos;
	assign tb.frame    = s.frame;
	assign tb.isF      = tb.fbitEn && (s.bitPos == '0);
	assign tb.slot     = rel[BIT_W-2:3];
	assign tb.frameEnd = (s.bitPos == fb - 10'h001);
	assign tb.preSync  = (s.bitPos == fb - 10'h002) && (s.frame == tb.framesM1);

	property p_wrap;
		@(posedge clk) disable iff (srst)
		(tb.step && !tb.load && tb.frameEnd) |=> (tb.bitPos == '0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("frame did not wrap");
endmodule : pst_timebase
`default_nettype wire

// file: sim/pst_far.sv
// Far side model: framer clocks, tx serial data, sync and channel payload
`timescale 1ns/1ps
`default_nettype none
module pst_far (
	input  wire logic	clk,
	input  wire logic	txRun,
	input  wire logic	extRun,
	input  wire logic	syncGo,
	input  wire logic	rxPayloadReq,
	output logic		txBitClock,
	output logic		externalRefClock,
	output logic		clockRecoveryLoopClk,
	output logic		txSerialIn,
	output logic		replaceDataIn,
	output logic		txFrameSyncIn,
	output logic		rxPayloadBit
);
	logic [2:0]	div;
	logic		armed;
	initial begin
		{div, armed, txBitClock, externalRefClock, clockRecoveryLoopClk} = '0;
		{txSerialIn, replaceDataIn, txFrameSyncIn, rxPayloadBit} = '0;
	end
	// Eight system cycles per half period gives the 160 ns link clocks
	always @(posedge clk) begin
		div <= div + 3'h1;
		if (rxPayloadReq)
			rxPayloadBit <= ~rxPayloadBit;
		if (div == 3'h7) begin
			clockRecoveryLoopClk <= ~clockRecoveryLoopClk;
			if (extRun)
				externalRefClock <= ~externalRefClock;
			if (txRun && !txBitClock) begin
				// Data and sync change on the rising edge, away from the sample edge
				txSerialIn    <= 1'h1;
				replaceDataIn <= 1'h0;
				txFrameSyncIn <= syncGo && !armed;
				armed         <= syncGo;
			end
			if (txRun)
				txBitClock <= ~txBitClock;
		end
	end
endmodule : pst_far
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench of the PCM serial port timebase
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pst_pkg::*;
	logic			clk = 1'h0;
	logic			srst = 1'h1;
	logic [ADDR_W-1:0]	avs_address = '0;
	logic			avs_read = 1'h0;
	logic			avs_write = 1'h0;
	logic [DATA_W-1:0]	avs_writedata = '0;
	logic [BE_W-1:0]	avs_byteenable = '0;
	logic [DATA_W-1:0]	avs_readdata;
	logic			avs_waitrequest, txBitClock, externalRefClock, clockRecoveryLoopClk;
	logic			txSerialIn, txFrameSyncIn, replaceDataIn, insertMarker;
	logic			txMasterSyncOut, txPayloadBit, txPayloadValid, txPayloadFbit;
	logic			rxPayloadBit, rxPayloadReq, rxBitClockOut, rxSerialOut;
	logic			rxFrameSyncOut, dropMarker, d1, d2, d3, msPrev, syncPrev;
	logic			txRun = 1'h1;
	logic			extRun = 1'h0;
	logic			syncGo = 1'h0;
	int			mismatches = 0, testsRun = 0, cyc = 0, reqTot = 0, valTot = 0;
	int			rxBits, dropBits, rxSeen, gap, gapVal, expGap = 0;
	int			txBits, zeros, txSeen, since;
	bit			rxOn = 0, txOn = 0, clkOn = 0, gapOpen = 0, armS = 0, track = 0, invOn = 0;

	pst_far far (.clk, .txRun, .extRun, .syncGo, .rxPayloadReq, .txBitClock,
		.externalRefClock, .clockRecoveryLoopClk, .txSerialIn, .replaceDataIn,
		.txFrameSyncIn, .rxPayloadBit);
	pst_top uut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .txBitClock, .externalRefClock,
		.clockRecoveryLoopClk, .txSerialIn, .txFrameSyncIn, .replaceDataIn,
		.insertMarker, .txMasterSyncOut, .txPayloadBit, .txPayloadValid, .txPayloadFbit,
		.rxPayloadBit, .rxPayloadReq, .rxBitClockOut, .rxSerialOut, .rxFrameSyncOut,
		.dropMarker);

	always #5 clk = ~clk;

	task automatic conclude;
		$display("checks %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One access, entered just after an edge; one idle edge follows the release
	task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge clk);
		while (avs_waitrequest !== 1'h0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		q = avs_readdata;
		if (n >= 50)
			chk("bus answer", 0, 1);
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge clk);
	endtask : acc

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		acc(1'h1, a, d, be, q);
	endtask : wr

	task automatic rdc(input logic [5:0] a, input logic [31:0] e, input string what);
		logic [31:0] q;
		acc(1'h0, a, 32'h0, 4'hF, q);
		chk(what, e, q);
	endtask : rdc

	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			conclude();
		end
	end

	always @(posedge clk) begin
		d3 <= d2;
		d2 <= d1;
		d1 <= txBitClock;
		msPrev <= txMasterSyncOut;
		syncPrev <= txFrameSyncIn;
		if (clkOn)
			chk("rx clock", d3, rxBitClockOut);
		if (clkOn && rxPayloadReq)
			chk("rx edge", !invOn, rxBitClockOut);
		if (clkOn && txPayloadValid)
			chk("tx edge", invOn, d3);
		if (!rxOn)
			rxSeen = 0;
		if (!txOn)
			txSeen = 0;
		if (!srst && rxPayloadReq) begin
			reqTot++;
			chk("rx data", rxPayloadBit, rxSerialOut);
			if (rxFrameSyncOut) begin
				if (rxOn && rxSeen > 0) begin
					chk("rx bits", 34, rxBits);
					chk("drop bits", 18, dropBits);
					chk("sync place", expGap, gapVal);
				end
				rxSeen++;
				{rxBits, dropBits, gap} = '0;
				gapOpen = 1;
			end
			rxBits++;
			dropBits += dropMarker;
			if (gapOpen) begin
				if (dropMarker) begin
					gapVal = gap;
					gapOpen = 0;
				end else
					gap++;
			end
		end
		if (txFrameSyncIn && !syncPrev)
			armS = 1;
		if (txPayloadValid) begin
			valTot++;
			if (armS) begin
				chk("sync sample", 1, txPayloadFbit);
				{armS, since, txSeen} = '0;
				track = 1;
			end else
				since++;
			if (track && txOn && txPayloadFbit)
				chk("f place", 0, since % 17);
			txBits++;
			zeros += !txPayloadBit;
		end
		if (txMasterSyncOut && !msPrev) begin
			if (txOn && txSeen > 0) begin
				chk("tx bits", 34, txBits);
				chk("insert bits", 16, zeros);
			end
			txSeen++;
			{txBits, zeros} = '0;
		end
	end

	initial begin
		int n;
		repeat (12) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		rdc(ADR_CTRL, 32'h0000_0040, "ctrl");
		rdc(ADR_FRM, 32'h0000_0F1F, "frm");
		wr(6'h28, 32'hFFFF_FFFF, 4'hF);
		rdc(6'h28, 32'h0, "unmapped");
		wr(ADR_FRM, 32'hFFFF_FFFF, 4'h1);
		rdc(ADR_FRM, 32'h0000_0F3F, "frm lane");
		wr(ADR_FRM, 32'h0000_0101, 4'hF);
		wr(ADR_CTRL, 32'h0000_00C0, 4'hF);
		wr(ADR_DROPLO, 32'h2, 4'hF);
		wr(ADR_FMASK, 32'h1, 4'hF);
		wr(ADR_INSLO, 32'h1, 4'hF);
		// Old 256-bit frame must end before the short frame is live
		repeat (5000) @(posedge clk);
		rxOn = 1;
		txOn = 1;
		repeat (2000) @(posedge clk);
		rxOn = 0;
		expGap = 4;
		wr(ADR_RXOFF, 32'h0001_0005, 4'hF);
		repeat (800) @(posedge clk);
		rxOn = 1;
		repeat (2000) @(posedge clk);
		syncGo <= 1'h1;
		repeat (2000) @(posedge clk);
		syncGo <= 1'h0;
		rxOn = 0;
		txOn = 0;
		wr(ADR_CTRL, 32'h0000_00C4, 4'hF);
		repeat (800) @(posedge clk);
		n = reqTot;
		repeat (400) @(posedge clk);
		chk("rx stall", n, reqTot);
		extRun <= 1'h1;
		repeat (400) @(posedge clk);
		chk("rx on ext", 1, reqTot > n);
		wr(ADR_CTRL, 32'h0000_00C6, 4'hF);
		repeat (800) @(posedge clk);
		txRun <= 1'h0;
		n = valTot;
		repeat (400) @(posedge clk);
		chk("tx on ext", 1, valTot > n);
		wr(ADR_CTRL, 32'h0000_00C5, 4'hF);
		repeat (800) @(posedge clk);
		n = valTot;
		repeat (400) @(posedge clk);
		chk("tx on rx", 1, valTot > n);
		txRun <= 1'h1;
		wr(ADR_CTRL, 32'h0000_00C8, 4'hF);
		repeat (800) @(posedge clk);
		clkOn = 1;
		repeat (200) @(posedge clk);
		clkOn = 0;
		// Both edges inverted, rx still timed by the tx pin
		wr(ADR_CTRL, 32'h0000_00F8, 4'hF);
		repeat (800) @(posedge clk);
		invOn = 1;
		clkOn = 1;
		repeat (200) @(posedge clk);
		clkOn = 0;
		conclude();
	end
endmodule : tb
`default_nettype wire
